// ==== hdl/isas_pkg.sv ====
package isas_pkg;
  // ----------------------------------------------------------------
  // Addressing
  // ----------------------------------------------------------------
  localparam logic [6:0] PIN_ADDR_BASE  = 7'h34;  // 0110_1xx upper seven bits, select bits cleared
  localparam int         SEL_LOW_POS    = 0;      // Address bit set by low select pin (byte bit 1)
  localparam int         SEL_HIGH_POS   = 1;      // Address bit set by high select pin (byte bit 2)
  localparam logic [6:0] GENERIC_ADDR   = 7'h0E;  // 0001_110 upper seven bits
  localparam int         RW_POS         = 0;      // Direction bit in the address byte
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         CLK_HZ         = 25_000_000;  // System clock rate
  localparam int         SCL_MAX_HZ     = 400_000;     // Fastest serial clock served
  localparam int         CYC_PER_SCL    = CLK_HZ / SCL_MAX_HZ;  // Cycles in one fast-mode period
  localparam int         FILT_LEN       = 2;           // Glitch filter depth in cycles
  // ----------------------------------------------------------------
  // Transfer states
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ISAS_IDLE = 6'b000001,  // Waiting for start
    ISAS_ADDR = 6'b000010,  // Shifting address byte
    ISAS_AACK = 6'b000100,  // Address acknowledge slot
    ISAS_RXB  = 6'b001000,  // Receiving data byte
    ISAS_TXB  = 6'b010000,  // Sending data byte
    ISAS_ACK  = 6'b100000   // Data acknowledge slot
  } isas_state_e;
endpackage : isas_pkg

// ==== hdl/isas_filter.sv ====
`timescale 1ns/1ps
`default_nettype none
// Majority-free glitch filter: output follows input once stable for LEN cycles
module isas_filter #(
  parameter int LEN = 2
) (
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic din,
  output var  logic dout,
  output var  logic rise,
  output var  logic fall
);
  // ----------------------------------------------------------------
  // Stability counter
  // ----------------------------------------------------------------
  logic [3:0] cnt;  // Cycles the input has differed from the output

  // Counter is four bits wide, so the depth is bounded
  if (LEN < 1 || LEN > 15) begin : g_bad_len
    $error("isas_filter: LEN out of range");
  end

  // Count disagreement, flip output when stable long enough
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt  <= 4'h0;
      dout <= 1'b1;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      rise <= 1'b0;
      fall <= 1'b0;
      if (din == dout) begin
        cnt <= 4'h0;
      end else if (cnt == 4'(LEN - 1)) begin
        // Input held long enough: accept it
        cnt  <= 4'h0;
        dout <= din;
        rise <= din;
        fall <= ~din;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule : isas_filter
`default_nettype wire

// ==== hdl/isas_slave.sv ====
`timescale 1ns/1ps
`default_nettype none
module isas_slave #(
  parameter int FILT = isas_pkg::FILT_LEN
) (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output var  logic       sda_out,
  output var  logic       sda_oe_n,
  input  wire logic       addr_select_low_pin,
  input  wire logic       addr_select_high_pin,
  output var  logic       rx_valid,
  output var  logic [7:0] rx_data,
  output var  logic       rx_first,
  input  wire logic [7:0] tx_data,
  output var  logic       tx_req,
  output var  logic       busy
);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // filter fits period
  if (4 * (FILT + 2) >= isas_pkg::CYC_PER_SCL) begin : g_filt_slow
    $error("isas_slave: filter too slow for fast mode");
  end

  // ----------------------------------------------------------------
  // Line conditioning
  // ----------------------------------------------------------------
  logic scl_f;   // Filtered clock line
  logic scl_r;   // Clock rising
  logic scl_fl;  // Clock falling
  logic sda_f;   // Filtered data line
  logic sda_r;   // Data rising
  logic sda_fl;  // Data falling

  isas_filter #(.LEN(FILT)) u_scl (
    .clock (clock), .arst_n (arst_n), .din (scl_in),
    .dout  (scl_f), .rise (scl_r), .fall (scl_fl)
  );
  isas_filter #(.LEN(FILT)) u_sda (
    .clock (clock), .arst_n (arst_n), .din (sda_in),
    .dout  (sda_f), .rise (sda_r), .fall (sda_fl)
  );

  logic start_c;  // Start condition seen
  logic stop_c;   // Stop condition seen
  assign start_c = sda_fl & scl_f;
  assign stop_c  = sda_r & scl_f;

  // ----------------------------------------------------------------
  // Address match
  // ----------------------------------------------------------------
  logic [6:0] pin_addr;  // Address chosen by select pins
  logic       hit;       // Received address is ours

  always_comb begin
    pin_addr                        = isas_pkg::PIN_ADDR_BASE;
    pin_addr[isas_pkg::SEL_LOW_POS]  = addr_select_low_pin;
    pin_addr[isas_pkg::SEL_HIGH_POS] = addr_select_high_pin;
  end

  logic [7:0] shreg;  // Shift register
  logic [2:0] bitn;   // Bits taken in current byte

  assign hit = (shreg[7:1] == pin_addr) || (shreg[7:1] == isas_pkg::GENERIC_ADDR);

  // ----------------------------------------------------------------
  // Byte boundary
  // ----------------------------------------------------------------
  logic full;  // Eight clock rises taken since the byte began

  // byte complete flag
  // The bit counter reads zero both before the first rise and after the
  // eighth, so the clock fall that follows a start needs this flag to
  // avoid passing for the end of a byte
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      full <= 1'b0;
    end else if (start_c || stop_c) begin
      // A new frame always begins empty
      full <= 1'b0;
    end else if (scl_r) begin
      // Set by the rise that wraps the counter
      full <= (bitn == 3'h7);
    end else if (scl_fl) begin
      // Dropped by the fall that closes the byte
      full <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transfer engine
  // ----------------------------------------------------------------
  isas_pkg::isas_state_e state;  // Current phase
  logic                  rd;     // Transfer is a read
  logic                  nack;   // Master refused last read byte
  logic                  first;  // Next received byte is first after address

  // Sequencing on filtered edges
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state    <= isas_pkg::ISAS_IDLE;
      shreg    <= 8'h00;
      bitn     <= 3'h0;
      rd       <= 1'b0;
      nack     <= 1'b0;
      first    <= 1'b0;
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
      rx_first <= 1'b0;
      tx_req   <= 1'b0;
      sda_out  <= 1'b1;
    end else begin
      rx_valid <= 1'b0;
      tx_req   <= 1'b0;
      if (start_c) begin
        // Start or repeated start always resynchronises
        state   <= isas_pkg::ISAS_ADDR;
        bitn    <= 3'h0;
        sda_out <= 1'b1;
      end else if (stop_c) begin
        state   <= isas_pkg::ISAS_IDLE;
        sda_out <= 1'b1;
      end else begin
        unique case (state)
          isas_pkg::ISAS_IDLE: begin
            sda_out <= 1'b1;
          end
          isas_pkg::ISAS_ADDR: begin
            if (scl_r) begin
              shreg <= {shreg[6:0], sda_f};
              bitn  <= bitn + 3'h1;
            end else if (scl_fl && full) begin
              if (hit) begin
                rd      <= shreg[isas_pkg::RW_POS];
                sda_out <= 1'b0;
                state   <= isas_pkg::ISAS_AACK;
                first   <= 1'b1;
                tx_req  <= shreg[isas_pkg::RW_POS];
              end else begin
                sda_out <= 1'b1;
                state   <= isas_pkg::ISAS_IDLE;
              end
            end
          end
          isas_pkg::ISAS_AACK, isas_pkg::ISAS_ACK: begin
            // End of acknowledge clock
            if (scl_r && state == isas_pkg::ISAS_ACK && rd) begin
              nack <= sda_f;
            end
            if (scl_fl) begin
              bitn <= 3'h0;
              if (rd && !(state == isas_pkg::ISAS_ACK && nack)) begin
                shreg   <= {tx_data[6:0], 1'b1};
                sda_out <= tx_data[7];
                state   <= isas_pkg::ISAS_TXB;
              end else if (rd) begin
                // Master ended read: release until stop
                sda_out <= 1'b1;
                state   <= isas_pkg::ISAS_IDLE;
              end else begin
                sda_out <= 1'b1;
                state   <= isas_pkg::ISAS_RXB;
              end
            end
          end
          isas_pkg::ISAS_RXB: begin
            if (scl_r) begin
              shreg <= {shreg[6:0], sda_f};
              bitn  <= bitn + 3'h1;
            end else if (scl_fl && full) begin
              rx_valid <= 1'b1;
              rx_data  <= shreg;
              rx_first <= first;
              first    <= 1'b0;
              sda_out  <= 1'b0;
              state    <= isas_pkg::ISAS_ACK;
            end
          end
          isas_pkg::ISAS_TXB: begin
            if (scl_r) begin
              bitn <= bitn + 3'h1;
            end else if (scl_fl) begin
              if (bitn == 3'h0) begin
                sda_out <= 1'b1;
                state   <= isas_pkg::ISAS_ACK;
                tx_req  <= 1'b1;
              end else begin
                sda_out <= shreg[7];
                shreg   <= {shreg[6:0], 1'b1};
              end
            end
          end
          default: begin
            state <= isas_pkg::ISAS_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // open drain, only pulls low
  assign sda_oe_n = sda_out;
  assign busy     = (state != isas_pkg::ISAS_IDLE);
endmodule : isas_slave
`default_nettype wire

// ==== sim/isas_slave_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module isas_slave_checker (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic rx_valid,
  input wire logic tx_req,
  input wire logic busy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // Acknowledge arrives shortly after a byte lands
  sequence s_ack;
    ##[0:6] !sda_oe_n;
  endsequence
  // A driven low bit lasts at least eight cycles
  sequence s_hold;
    !sda_oe_n [*8];
  endsequence
  AST_OPEN_FREE: assert property ($rose(busy) |-> sda_oe_n)
    else $error("data driven as a transfer opened");
  AST_SCL_LOW: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("data line moved while clock high");
  AST_LOW_HOLD: assert property ($fell(sda_oe_n) |=> s_hold)
    else $error("driven bit too short");
  AST_IDLE_FREE: assert property (!busy |-> sda_oe_n)
    else $error("data driven while idle");
  AST_RX_ONE: assert property (rx_valid |=> !rx_valid)
    else $error("receive pulse too long");
  AST_TX_ONE: assert property (tx_req |=> !tx_req)
    else $error("send request too long");
  AST_RX_ACK: assert property (rx_valid |-> s_ack)
    else $error("received byte not acknowledged");
  AST_TX_BUSY: assert property (tx_req |-> busy)
    else $error("send request outside transfer");
endmodule : isas_slave_checker
`default_nettype wire

// ==== sim/isas_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module isas_host (
  input  wire logic clock,
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_oe_n
);
  // Half a bit period in 40 ns cycles, keeping the bus at or under 400 kHz
  localparam int HALF = 32;
  initial begin
    scl = 1'b1;
    sda_oe_n = 1'b1;
  end
  task automatic hp;
    repeat (HALF) @(negedge clock);
  endtask : hp
  task automatic start;
    sda_oe_n = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    sda_oe_n = 1'b0;
    hp();
    scl = 1'b0;
  endtask : start
  task automatic stop;
    sda_oe_n = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_oe_n = 1'b1;
    hp();
  endtask : stop
  // Data set while clock low, read at end of high
  task automatic xbit(input logic b, output logic r);
    sda_oe_n = b;
    hp();
    scl = 1'b1;
    hp();
    r = sda;
    scl = 1'b0;
  endtask : xbit
  // eight bits MSB first then the ack slot
  task automatic xbyte(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
    xbit(m, a);
  endtask : xbyte
endmodule : isas_host
`default_nettype wire

// ==== sim/test_i2c_slave_address_select.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_count++; $display("ERROR %0t mismatch", $time); end end
module test_i2c_slave_address_select;
  logic       clock = 1'b0;
  logic       arst_n = 1'b0;
  logic [1:0] pins = 2'h0;
  logic [7:0] tx_data = 8'h00;
  logic [7:0] q;
  logic       a;
  wire  logic scl, h_oe_n, sda_out, sda_oe_n, rx_valid, rx_first, tx_req, busy;
  wire  logic [7:0] rx_data;
  // Pulled-up wire, low when any party drives
  wire  logic sda = h_oe_n & sda_oe_n;
  int err_count = 0, checks_done = 0, cyc = 0, n_rx = 0;
  isas_slave dut (.clock, .arst_n, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe_n,
    .addr_select_low_pin(pins[0]), .addr_select_high_pin(pins[1]), .rx_valid, .rx_data,
    .rx_first, .tx_data, .tx_req, .busy);
  isas_host h (.clock, .sda, .scl, .sda_oe_n(h_oe_n));
  initial forever #20 clock = ~clock;
  // Count received bytes and cut a hang short
  always @(posedge clock) begin
    cyc++;
    if (rx_valid === 1'b1) n_rx++;
    if (cyc == 40000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    if (err_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // Every pin setting against every pin address
  task automatic t_sel;
    for (int p = 0; p < 4; p++)
      for (int s = 0; s < 4; s++) begin
        pins = p[1:0];
        h.start();
        h.xbyte({5'h0D, s[1:0], 1'b0}, 1'b1, q, a);
        h.stop();
        `CHK(a, p != s)
      end
  endtask : t_sel
  // Write one byte, then repeated start and read two
  task automatic t_wr(input logic [6:0] ad, input logic [7:0] d);
    h.start();
    h.xbyte({ad, 1'b0}, 1'b1, q, a);
    `CHK(a, 1'b0)
    h.xbyte(d, 1'b1, q, a);
    `CHK(a, 1'b0)
    `CHK(rx_data, d)
    `CHK(rx_first, 1'b1)
    tx_data = ~d;
    h.start();
    h.xbyte({ad, 1'b1}, 1'b1, q, a);
    `CHK(a, 1'b0)
    h.xbyte(8'hFF, 1'b0, q, a);
    `CHK(q, ~d)
    h.xbyte(8'hFF, 1'b1, q, a);
    `CHK(q, ~d)
    h.stop();
  endtask : t_wr
  // Foreign address, then a byte that looks like ours
  task automatic t_ign;
    int n;
    n = n_rx;
    pins = 2'h0;
    h.start();
    h.xbyte(8'h3C, 1'b1, q, a);
    `CHK(a, 1'b1)
    h.xbyte(8'h68, 1'b1, q, a);
    h.stop();
    `CHK(a, 1'b1)
    `CHK(n_rx, n)
  endtask : t_ign
  initial begin
    repeat (8) @(negedge clock);
    arst_n = 1'b1;
    @(negedge clock);
    t_sel();
    pins = 2'h2;
    t_wr(7'h0E, 8'hC3);
    t_wr(7'h36, 8'h5A);
    t_ign();
    tally_and_finish();
  end
endmodule : test_i2c_slave_address_select
bind isas_slave isas_slave_checker u_chk (.clock, .arst_n, .scl_in, .sda_out, .sda_oe_n, .rx_valid,
  .tx_req, .busy);
`default_nettype wire
